// File: core/dmacs_regs.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dmacs_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [dmacs_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dmacs_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic grant_valid,
	input wire logic [4:0] grant_channel,
	input wire logic active_channel_busy,
	input wire logic [15:0] active_block_count,
	input wire logic [dmacs_pkg::NUM_CH-1:0] chan_pending,
	input wire logic [dmacs_pkg::NUM_CH-1:0] chan_busy,
	input wire logic [dmacs_pkg::NUM_CH-1:0] chan_complete,
	input wire logic [dmacs_pkg::NUM_CH-1:0] chan_drained,
	output logic controller_enable,
	output logic [31:0] descriptor_section_base,
	output logic [31:0] writeback_section_base,
	output logic [dmacs_pkg::NUM_CH-1:0] channel_enable,
	output logic [dmacs_pkg::NUM_CH-1:0] channel_abort,
	output dmacs_pkg::dmacs_chcfg_t [dmacs_pkg::NUM_CH-1:0] channel_config,
	output logic [dmacs_pkg::NUM_CH-1:0][2:0] event_action_active
);
	// Index decode shared by the read and the write path
	function automatic dmacs_pkg::dmacs_reg_t decode(
		input logic [dmacs_pkg::AW-1:0] a);
		logic [7:0] idx;
		idx = a[dmacs_pkg::AW-1:2];
		case (idx)
		dmacs_pkg::IDX_GCTRL: decode = dmacs_pkg::R_GCTRL;
		dmacs_pkg::IDX_PROT: decode = dmacs_pkg::R_PROT;
		dmacs_pkg::IDX_ACTIVE: decode = dmacs_pkg::R_ACTIVE;
		dmacs_pkg::IDX_DESC: decode = dmacs_pkg::R_DESC;
		dmacs_pkg::IDX_WB: decode = dmacs_pkg::R_WB;
		dmacs_pkg::IDX_SEL: decode = dmacs_pkg::R_SEL;
		dmacs_pkg::IDX_CHA: decode = dmacs_pkg::R_CHA;
		dmacs_pkg::IDX_CHB: decode = dmacs_pkg::R_NONE;
		default: decode = dmacs_pkg::R_NONE;
		endcase
	endfunction

	function automatic logic is_chb(input logic [dmacs_pkg::AW-1:0] a);
		is_chb = (a[dmacs_pkg::AW-1:2] == dmacs_pkg::IDX_CHB);
	endfunction

	// Byte-lane merge of new data into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic [31:0] chb_word(input dmacs_pkg::dmacs_chcfg_t c);
		chb_word = 32'h0000_0000;
		chb_word[dmacs_pkg::CMD_LSB +: 2] = c.cmd;
		chb_word[dmacs_pkg::TRIG_ACT_LSB +: 2] = c.trigger_action;
		chb_word[dmacs_pkg::TRIG_SRC_LSB +: 6] = c.trigger_source;
		chb_word[dmacs_pkg::ARB_LSB +: 2] = c.arbitration_level;
		chb_word[dmacs_pkg::EV_OUT_BIT] = c.event_output_enable;
		chb_word[dmacs_pkg::EV_IN_BIT] = c.event_input_enable;
		chb_word[dmacs_pkg::EV_ACT_LSB +: 3] = c.event_input_action;
	endfunction

	logic aw_held_q;
	logic w_held_q;
	logic [dmacs_pkg::AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic gctrl_en_q;
	logic wp_q;
	logic [31:0] desc_q;
	logic [31:0] wb_q;
	logic [3:0] sel_q;
	logic [4:0] act_id_q;
	dmacs_pkg::dmacs_chst_t st_q [dmacs_pkg::NUM_CH];
	dmacs_pkg::dmacs_chcfg_t cfg_q [dmacs_pkg::NUM_CH];
	logic wr_go;
	dmacs_pkg::dmacs_reg_t wr_reg;
	logic wr_chb;
	logic sel_ok;
	logic wr_open;
	logic [31:0] wr_merged_a;
	logic [3:0] level_live;
	logic [31:0] rd_word;
	logic rd_hit;

	// A write commits once both halves are held and no answer is pending
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_go = aw_held_q && w_held_q && !bvalid_q;
	assign wr_reg = decode(awaddr_q);
	assign wr_chb = is_chb(awaddr_q);
	assign sel_ok = (sel_q < 4'(dmacs_pkg::NUM_CH));
	assign wr_open = wr_go && !wp_q; // RULE6
	assign wr_merged_a = merge(32'h0000_0000, wdata_q, wstrb_q);

	// Address and data are caught in either order
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// Write answer; unmapped words answer with a slave error
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= dmacs_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_reg == dmacs_pkg::R_NONE && !wr_chb) ?
				dmacs_pkg::RESP_SLVERR : dmacs_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Global registers; protection word itself stays writable as the key
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gctrl_en_q <= 1'b0;
			wp_q <= 1'b0;
			desc_q <= dmacs_pkg::BASE_RST;
			wb_q <= dmacs_pkg::BASE_RST;
			sel_q <= dmacs_pkg::SEL_RST;
		end else if (wr_go) begin
			case (wr_reg)
			dmacs_pkg::R_PROT: if (wstrb_q[0]) begin
				wp_q <= wdata_q[dmacs_pkg::PROT_WP_BIT];
			end
			dmacs_pkg::R_GCTRL: if (!wp_q && wstrb_q[0]) begin
				gctrl_en_q <= wdata_q[dmacs_pkg::GCTRL_EN_BIT];
			end
			dmacs_pkg::R_DESC: if (!wp_q && !gctrl_en_q) begin
				desc_q <= merge(desc_q, wdata_q, wstrb_q); // RULE6
			end
			dmacs_pkg::R_WB: if (!wp_q && !gctrl_en_q) begin
				wb_q <= merge(wb_q, wdata_q, wstrb_q); // RULE6
			end
			dmacs_pkg::R_SEL: if (wstrb_q[0]) begin
				sel_q <= wdata_q[3:0]; // RULE7
			end
			default: ;
			endcase
		end
	end

	// Active channel index follows each arbiter grant
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			act_id_q <= 5'h00;
		end else if (grant_valid) begin
			act_id_q <= grant_channel; // RULE1
		end
	end

	// Per-channel enable state and control bank
	for (genvar c = 0; c < dmacs_pkg::NUM_CH; c++) begin : g_ch
		logic hit;
		logic en_now;
		logic wr_en;
		logic wr_sr;
		logic wa;
		logic wb;
		dmacs_pkg::dmacs_chcfg_t nc;
		logic [31:0] mb;
		assign hit = wr_open && sel_ok && (sel_q == 4'(c)); // RULE20
		assign wa = hit && (wr_reg == dmacs_pkg::R_CHA) && wstrb_q[0];
		assign wb = hit && wr_chb;
		assign en_now = (st_q[c] == dmacs_pkg::CH_RUN) ||
			(st_q[c] == dmacs_pkg::CH_ABORT);
		assign wr_en = wr_merged_a[dmacs_pkg::CHA_EN_BIT];
		assign wr_sr = wr_merged_a[dmacs_pkg::CHA_SRST_BIT];
		assign mb = merge(chb_word(cfg_q[c]), wdata_q, wstrb_q);
		assign channel_enable[c] = en_now;
		assign channel_abort[c] = (st_q[c] == dmacs_pkg::CH_ABORT);
		assign channel_config[c] = cfg_q[c];
		// Event action only reaches the engine while event input is on
		assign event_action_active[c] = cfg_q[c].event_input_enable ?
			cfg_q[c].event_input_action : dmacs_pkg::EV_NONE; // RULE19

		// Enable is free of enable protection; soft reset is not
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				st_q[c] <= dmacs_pkg::CH_IDLE;
			end else begin
				case (st_q[c])
				dmacs_pkg::CH_IDLE: begin
					if (wa && wr_en) begin
						st_q[c] <= dmacs_pkg::CH_RUN; // RULE9 RULE12
					end else if (wa && wr_sr && !gctrl_en_q) begin
						st_q[c] <= dmacs_pkg::CH_SRST; // RULE13 RULE16
					end
				end
				dmacs_pkg::CH_RUN: begin
					// Software re-enable outranks completion; srst ignored
					if (wa && !wr_en) begin
						st_q[c] <= dmacs_pkg::CH_ABORT; // RULE10 RULE14
					end else if (chan_complete[c] && !(wa && wr_en)) begin
						st_q[c] <= dmacs_pkg::CH_IDLE; // RULE11
					end
				end
				dmacs_pkg::CH_ABORT: begin
					if (wa && wr_en) begin
						st_q[c] <= dmacs_pkg::CH_RUN;
					end else if (chan_drained[c] || chan_complete[c]) begin
						st_q[c] <= dmacs_pkg::CH_IDLE; // RULE10
					end
				end
				dmacs_pkg::CH_SRST: st_q[c] <= dmacs_pkg::CH_IDLE; // RULE15
				default: st_q[c] <= dmacs_pkg::CH_IDLE;
				endcase
			end
		end

		// Reserved codes are refused and leave the field as it was
		always_comb begin
			nc = cfg_q[c];
			if (mb[dmacs_pkg::CMD_LSB +: 2] != dmacs_pkg::CMD_RSVD) begin
				nc.cmd = mb[dmacs_pkg::CMD_LSB +: 2]; // RULE17
			end
			nc.arbitration_level = mb[dmacs_pkg::ARB_LSB +: 2];
			if (!gctrl_en_q) begin
				if (mb[dmacs_pkg::TRIG_ACT_LSB +: 2] != dmacs_pkg::TRIG_RSVD) begin
					nc.trigger_action = mb[dmacs_pkg::TRIG_ACT_LSB +: 2]; // RULE18
				end
				nc.trigger_source = mb[dmacs_pkg::TRIG_SRC_LSB +: 6];
				nc.event_output_enable = mb[dmacs_pkg::EV_OUT_BIT];
				nc.event_input_enable = mb[dmacs_pkg::EV_IN_BIT];
				if (mb[dmacs_pkg::EV_ACT_LSB +: 3] != dmacs_pkg::EV_RSVD) begin
					nc.event_input_action = mb[dmacs_pkg::EV_ACT_LSB +: 3];
				end
			end
		end

		// Bank cleared by soft reset; command and level escape enable lock
		always_ff @(posedge clk) begin
			if (!rst_n || st_q[c] == dmacs_pkg::CH_SRST) begin
				cfg_q[c] <= '0; // RULE13
			end else if (wb) begin
				cfg_q[c] <= nc; // RULE6
			end
		end
	end

	// A level is live when any channel of that level waits or runs
	always_comb begin
		level_live = 4'h0;
		for (int c = 0; c < dmacs_pkg::NUM_CH; c++) begin
			if (chan_pending[c] || chan_busy[c]) begin
				level_live[cfg_q[c].arbitration_level] = 1'b1; // RULE2
			end
		end
	end

	// Read mux; reserved bits and unselected banks read zero
	always_comb begin
		rd_word = 32'h0000_0000; // RULE3
		rd_hit = 1'b1;
		case (decode(s_axi_araddr))
		dmacs_pkg::R_GCTRL: rd_word[dmacs_pkg::GCTRL_EN_BIT] = gctrl_en_q;
		dmacs_pkg::R_PROT: rd_word[dmacs_pkg::PROT_WP_BIT] = wp_q;
		dmacs_pkg::R_ACTIVE: begin
			rd_word[dmacs_pkg::ACT_COUNT_LSB +: 16] = active_block_count;
			rd_word[dmacs_pkg::ACT_BUSY_BIT] = active_channel_busy;
			rd_word[dmacs_pkg::ACT_CHAN_LSB +: 5] = act_id_q; // RULE1
			rd_word[3:0] = level_live; // RULE2
		end
		dmacs_pkg::R_DESC: rd_word = desc_q;
		dmacs_pkg::R_WB: rd_word = wb_q;
		dmacs_pkg::R_SEL: rd_word[3:0] = sel_q;
		dmacs_pkg::R_CHA: if (sel_ok) begin
			rd_word[dmacs_pkg::CHA_EN_BIT] = channel_enable[sel_q]; // RULE20
			rd_word[dmacs_pkg::CHA_SRST_BIT] =
				(st_q[sel_q] == dmacs_pkg::CH_SRST); // RULE15
		end
		default: begin
			if (is_chb(s_axi_araddr)) begin
				if (sel_ok) begin
					rd_word = chb_word(cfg_q[sel_q]); // RULE20
				end
			end else begin
				rd_hit = 1'b0;
			end
		end
		endcase
	end

	// Read data is registered at the same edge that takes the address
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= dmacs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? dmacs_pkg::RESP_OKAY : dmacs_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign controller_enable = gctrl_en_q;
	assign descriptor_section_base = desc_q;
	assign writeback_section_base = wb_q;
endmodule

// File: core/dmacs_pkg.sv
// Functional notes
// [RULE1] Active channel index reloads on every arbiter grant of a channel request.
// [RULE2] Per-level bit reads one while a request of that level executes or waits.
// [RULE3] Reserved bits read zero; software writes zeros into them.
// [RULE4] Software loads descriptor section base quad-word aligned.
// [RULE5] Software loads write-back section base quad-word aligned.
// [RULE6] Both bases and both channel controls are enable- and write-protected; the code writes command and arbitration level regardless of enable.
// [RULE7] Four-bit channel selector picks the bank reached by per-channel addresses.
// [RULE8] Software programs the channel selector before any per-channel access.
// [RULE9] Writing one to channel enable enables the selected channel.
// [RULE10] Disabling keeps enable reading one until buffer drains and abort ends.
// [RULE11] Channel enable clears itself when the channel transaction completes.
// [RULE12] Channel enable stays writable under enable protection.
// [RULE13] Soft reset written one while disabled returns channel registers to reset.
// [RULE14] Soft reset written one is ignored while channel enable reads one.
// [RULE15] Soft reset reads one while in progress and self-clears when done.
// [RULE16] Writing zero to soft reset has no effect.
// [RULE17] Command field: 0 none, 1 suspend, 2 resume, 3 reserved.
// [RULE18] Trigger action: 0 block, 2 beat, 3 transaction, 1 reserved.
// [RULE19] Event action 0..6 coded as listed, acting only with event input enabled.
// [RULE20] Per-channel controls are one bank per channel, indexed by the selector.
package dmacs_pkg;
	localparam int NUM_CH = 12;
	localparam int AW = 10;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GCTRL = 8'h00;
	localparam logic [7:0] IDX_PROT = 8'h01;
	localparam logic [7:0] IDX_ACTIVE = 8'h30;
	localparam logic [7:0] IDX_DESC = 8'h34;
	localparam logic [7:0] IDX_WB = 8'h38;
	localparam logic [7:0] IDX_SEL = 8'h3F;
	localparam logic [7:0] IDX_CHA = 8'h40;
	localparam logic [7:0] IDX_CHB = 8'h44;
	// Field positions
	localparam int GCTRL_EN_BIT = 1;
	localparam int PROT_WP_BIT = 0;
	localparam int CHA_EN_BIT = 1;
	localparam int CHA_SRST_BIT = 0;
	localparam int CMD_LSB = 24;
	localparam int TRIG_ACT_LSB = 22;
	localparam int TRIG_SRC_LSB = 8;
	localparam int ARB_LSB = 5;
	localparam int EV_OUT_BIT = 4;
	localparam int EV_IN_BIT = 3;
	localparam int EV_ACT_LSB = 0;
	localparam int ACT_COUNT_LSB = 16;
	localparam int ACT_BUSY_BIT = 15;
	localparam int ACT_CHAN_LSB = 8;
	// Reset values
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [3:0] SEL_RST = 4'h0;
	// Field encodings with their reserved codes; bus responses
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_SUSPEND = 2'h1;
	localparam logic [1:0] CMD_RESUME = 2'h2;
	localparam logic [1:0] CMD_RSVD = 2'h3;
	localparam logic [1:0] TRIG_BLOCK = 2'h0;
	localparam logic [1:0] TRIG_RSVD = 2'h1;
	localparam logic [1:0] TRIG_BEAT = 2'h2;
	localparam logic [1:0] TRIG_TRANSACTION = 2'h3;
	localparam logic [2:0] EV_NONE = 3'h0;
	localparam logic [2:0] EV_SKIP = 3'h6;
	localparam logic [2:0] EV_RSVD = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_RUN = 2'b01,
		CH_ABORT = 2'b11,
		CH_SRST = 2'b10
	} dmacs_chst_t;

	typedef enum logic [2:0] {
		R_NONE, R_GCTRL, R_PROT, R_ACTIVE, R_DESC, R_WB, R_SEL, R_CHA
	} dmacs_reg_t;

	typedef struct packed {
		logic [1:0] cmd;
		logic [1:0] trigger_action;
		logic [5:0] trigger_source;
		logic [1:0] arbitration_level;
		logic event_output_enable;
		logic event_input_enable;
		logic [2:0] event_input_action;
	} dmacs_chcfg_t;
endpackage

// File: tb/dmacs_regs_properties.sv
`timescale 1ns/1ps
// Register view and channel state checks, seen from the top ports only
module dmacs_regs_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic grant_valid,
	input wire logic [4:0] grant_channel,
	input wire logic [11:0] chan_pending,
	input wire logic [11:0] chan_busy,
	input wire logic [11:0] chan_complete,
	input wire logic [11:0] chan_drained,
	input wire logic controller_enable,
	input wire logic [31:0] descriptor_section_base,
	input wire logic [31:0] writeback_section_base,
	input wire logic [11:0] channel_enable,
	input wire logic [11:0] channel_abort,
	input wire dmacs_pkg::dmacs_chcfg_t [11:0] channel_config,
	input wire logic [11:0][2:0] event_action_active
);
	logic [7:0] ri_q;
	logic [4:0] g_q;
	logic [3:0] lv;
	logic [11:0] ce, dr, hold;
	logic bad, evm;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Read data is built at the address edge, so keep that index
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ri_q <= 8'h00;
			g_q <= 5'h00;
		end else begin
			if (s_axi_arvalid && s_axi_arready) ri_q <= s_axi_araddr[9:2];
			if (grant_valid) g_q <= grant_channel;
		end
	end

	// Channels whose enable must drop or hold at the next edge
	assign ce = chan_complete & channel_enable;
	assign dr = chan_drained & channel_abort;
	assign hold = channel_abort & ~chan_drained & ~chan_complete;

	// Level summary and scan for stored reserved codes
	always_comb begin
		lv = 4'h0;
		bad = 1'b0;
		evm = 1'b0;
		for (int i = 0; i < 12; i++) begin
			if (chan_pending[i] || chan_busy[i])
				lv[channel_config[i].arbitration_level] = 1'b1;
			if (channel_config[i].cmd == 2'h3) bad = 1'b1;
			if (channel_config[i].trigger_action == 2'h1) bad = 1'b1;
			if (channel_config[i].event_input_action == 3'h7) bad = 1'b1;
			if (event_action_active[i] != (channel_config[i].event_input_enable
				? channel_config[i].event_input_action : 3'h0)) evm = 1'b1;
		end
	end

	property p_act_id;
		$rose(s_axi_rvalid) && ri_q == 8'h30
			|-> s_axi_rdata[12:8] == $past(g_q);
	endproperty
	a_act_id: assert property (p_act_id) else $error("active index wrong");
	property p_level;
		$rose(s_axi_rvalid) && ri_q == 8'h30 |-> s_axi_rdata[3:0] == $past(lv);
	endproperty
	a_level: assert property (p_level) else $error("level bits wrong");
	property p_rsvd;
		$rose(s_axi_rvalid) |-> (ri_q != 8'h3F || s_axi_rdata[31:4] == 28'h0)
			&& (ri_q != 8'h40 || s_axi_rdata[31:2] == 30'h0)
			&& (ri_q != 8'h44 || (s_axi_rdata & 32'hFC3F_C080) == 32'h0)
			&& (ri_q != 8'h30 || (s_axi_rdata & 32'h0000_60F0) == 32'h0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_prot;
		controller_enable |=> $stable(descriptor_section_base)
			&& $stable(writeback_section_base);
	endproperty
	a_prot: assert property (p_prot) else $error("base changed");
	property p_rise;
		(channel_enable & ~$past(channel_enable)) != 12'h000
			|-> $rose(s_axi_bvalid);
	endproperty
	a_rise: assert property (p_rise) else $error("enable rose alone");
	property p_hold;
		hold != 12'h000 |=> (channel_enable & $past(hold)) == $past(hold);
	endproperty
	a_hold: assert property (p_hold) else $error("enable left early");
	property p_drain;
		dr != 12'h000 |=> (channel_enable & $past(dr)) == 12'h000
			|| $rose(s_axi_bvalid);
	endproperty
	a_drain: assert property (p_drain) else $error("drain kept on");
	property p_done;
		ce != 12'h000 |=> (channel_enable & $past(ce)) == 12'h000
			|| $rose(s_axi_bvalid);
	endproperty
	a_done: assert property (p_done) else $error("done kept on");
	property p_codes;
		!bad;
	endproperty
	a_codes: assert property (p_codes) else $error("bad code");
	property p_ev;
		!evm;
	endproperty
	a_ev: assert property (p_ev) else $error("event action wrong");
endmodule

bind dmacs_regs dmacs_regs_properties u_props (
	.clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .grant_valid,
	.grant_channel, .chan_pending, .chan_busy, .chan_complete,
	.chan_drained, .controller_enable, .descriptor_section_base,
	.writeback_section_base, .channel_enable, .channel_abort,
	.channel_config, .event_action_active
);

// File: tb/dmacs_engine_model.sv
`timescale 1ns/1ps
// Arbiter and transfer engine stand-in beside the register slice
module dmacs_engine_model #(
	parameter int DRAIN_DLY = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] channel_abort,
	output logic grant_valid,
	output logic [4:0] grant_channel,
	output logic [11:0] chan_complete,
	output logic [11:0] chan_drained
);
	int cnt;

	initial begin
		grant_valid = 1'b0;
		grant_channel = 5'h1F;
		chan_complete = 12'h000;
		chan_drained = 12'h000;
	end

	// Buffer empties only a while after abort; done is a one-cycle pulse
	always @(posedge clk) begin
		chan_drained <= 12'h000;
		if (!rst_n || channel_abort == 12'h000) begin
			cnt <= DRAIN_DLY;
		end else if (cnt == 0) begin
			chan_drained <= channel_abort;
			cnt <= DRAIN_DLY;
		end else begin
			cnt <= cnt - 1;
		end
	end

	// Grant pulse; index is inverted when idle so no stale value lingers
	task automatic grant(input logic [4:0] ch);
		@(posedge clk);
		grant_valid <= 1'b1;
		grant_channel <= ch;
		@(posedge clk);
		grant_valid <= 1'b0;
		grant_channel <= ~ch;
	endtask

	task automatic complete(input int ch);
		@(posedge clk);
		chan_complete <= 12'(1) << ch;
		@(posedge clk);
		chan_complete <= 12'h000;
	endtask
endmodule

// File: tb/test_dma_channel_select_control.sv
`timescale 1ns/1ps
module test_dma_channel_select_control;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] s_axi_awaddr = 10'h000;
	logic [9:0] s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic active_channel_busy = 1'b0;
	logic [15:0] active_block_count = 16'h0000;
	logic [11:0] chan_pending = 12'h000;
	logic [11:0] chan_busy = 12'h000;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, grant_valid, controller_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, descriptor_section_base, writeback_section_base;
	logic [4:0] grant_channel;
	logic [11:0] chan_complete, chan_drained, channel_enable, channel_abort;
	dmacs_pkg::dmacs_chcfg_t [11:0] channel_config;
	logic [11:0][2:0] event_action_active;
	logic [7:0] rt [5] = '{8'h34, 8'h38, 8'h3F, 8'h40, 8'h44};
	int error_cnt = 0;
	int tests_run = 0;

	dmacs_regs dut (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .grant_valid, .grant_channel,
		.active_channel_busy, .active_block_count, .chan_pending,
		.chan_busy, .chan_complete, .chan_drained, .controller_enable,
		.descriptor_section_base, .writeback_section_base, .channel_enable,
		.channel_abort, .channel_config, .event_action_active
	);

	dmacs_engine_model eng (
		.clk, .rst_n, .channel_abort, .grant_valid, .grant_channel,
		.chan_complete, .chan_drained
	);

	initial forever #12.5 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] i, input logic [31:0] d,
		input logic [1:0] er = 2'h0, input logic [3:0] st = 4'hF);
		logic a, b;
		a = 1'b1;
		b = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (a || b) begin
			@(posedge clk);
			if (a && s_axi_awready) begin
				a = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (b && s_axi_wready) begin
				b = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rd(input logic [7:0] i, input logic [31:0] e,
		input string n, input logic [1:0] er = 2'h0);
		@(posedge clk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(n, e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	// Second control word per channel; sweeps every legal code
	function automatic logic [31:0] chb(input int c);
		logic [1:0] t;
		t = (c % 3 == 0) ? 2'h0 : 2'(c % 3 + 1);
		return {6'h00, 2'(c % 3), t, 8'h00, 6'(c), 1'b0, 2'(c % 4), 2'h1,
			3'(c % 7)};
	endfunction

	task automatic final_report();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rt[k]) rd(rt[k], 32'h0, "reset_val");
		rd(8'h02, 32'h0, "unmapped", 2'h2);
		wr(8'h02, 32'hFFFF_FFFF, 2'h2);
		wr(8'h34, 32'h2000_0010);
		wr(8'h38, 32'h2000_FF00);
		// Low two lanes only: upper half must survive the merge
		wr(8'h38, 32'h5555_0200, 2'h0, 4'h3);
		chk("desc", 32'h2000_0010, descriptor_section_base);
		rd(8'h38, 32'h2000_0200, "wb_base");
		wr(8'h3F, 32'h0000_00FF);
		rd(8'h3F, 32'h0000_000F, "selector");
		rd(8'h44, 32'h0, "no_bank");
		for (int c = 0; c < 12; c++) begin
			wr(8'h3F, 32'(c));
			wr(8'h44, chb(c) | 32'hFC3F_C080);
		end
		for (int c = 0; c < 12; c++) begin
			wr(8'h3F, 32'(c));
			rd(8'h44, chb(c), "ctrl_second");
			chk("ev_act", 32'(c % 7), 32'(event_action_active[c]));
		end
		wr(8'h44, 32'h0340_0007);
		rd(8'h44, 32'h02C0_0004, "rsvd_codes");
		chk("ev_off", 32'h0, 32'(event_action_active[11]));
		chan_pending <= 12'h020;
		chan_busy <= 12'h004;
		active_channel_busy <= 1'b1;
		active_block_count <= 16'hA5C3;
		eng.grant(5'h07);
		rd(8'h30, 32'hA5C3_8706, "active");
		chan_pending <= 12'h000;
		chan_busy <= 12'h000;
		eng.grant(5'h03);
		rd(8'h30, 32'hA5C3_8300, "active_idle");
		wr(8'h00, 32'h2);
		wr(8'h34, 32'h3000_0000);
		rd(8'h34, 32'h2000_0010, "desc_prot");
		wr(8'h3F, 32'h4);
		wr(8'h40, 32'h2);
		rd(8'h40, 32'h2, "enable");
		eng.complete(4);
		rd(8'h40, 32'h0, "completed");
		wr(8'h01, 32'h1);
		wr(8'h38, 32'h0000_0100);
		rd(8'h38, 32'h2000_0200, "wb_prot");
		wr(8'h01, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h40, 32'h2);
		wr(8'h40, 32'h3);
		rd(8'h40, 32'h2, "srst_ignored");
		rd(8'h44, chb(4), "srst_kept");
		wr(8'h40, 32'h0);
		rd(8'h40, 32'h2, "abort_hold");
		chk("abort", 32'h1, 32'(channel_abort[4]));
		repeat (16) @(posedge clk);
		rd(8'h40, 32'h0, "drained");
		wr(8'h40, 32'h0);
		rd(8'h44, chb(4), "srst_zero");
		wr(8'h40, 32'h1);
		rd(8'h40, 32'h0, "srst_done");
		rd(8'h44, 32'h0, "srst_bank");
		final_report();
	end
endmodule
